//--- logic/act_pkg.sv
package act_pkg;
    // register offsets on the control port
    localparam logic [7:0] ACT_OFS_CH2_VOL = 8'h57;
    localparam logic [7:0] ACT_OFS_CH2_FINE = 8'h58;
    localparam logic [7:0] ACT_OFS_CH2_PHASE = 8'h59;
    localparam logic [7:0] ACT_OFS_CH3_COPY = 8'h5A;
    localparam logic [7:0] ACT_OFS_CH3_VOL = 8'h5B;
    localparam logic [7:0] ACT_OFS_CH3_FINE = 8'h5C;
    // reset values
    localparam logic [7:0] ACT_RST_VOL = 8'hA1;
    localparam logic [7:0] ACT_RST_FINE = 8'h80;
    localparam logic [7:0] ACT_RST_PHASE = 8'h00;
    localparam logic [7:0] ACT_RST_COPY = 8'h00;
    // writable bits; the rest are reserved and read as zero
    localparam logic [7:0] ACT_MASK_VOL = 8'hFF;
    localparam logic [7:0] ACT_MASK_FINE = 8'hF0;
    localparam logic [7:0] ACT_MASK_PHASE = 8'hFC;
    localparam logic [7:0] ACT_MASK_COPY = 8'h80;
    // field positions
    localparam int ACT_FINE_LSB = 4;
    localparam int ACT_PHASE_LSB = 2;
    localparam int ACT_COPY_BIT = 7;
    // code points
    localparam logic [7:0] ACT_VOL_MUTE = 8'h00;
    localparam logic [8:0] ACT_VOL_BIAS = 9'h007;
    localparam logic [8:0] ACT_VOL_STEPS_PER_OCT = 9'h00C;
    localparam logic signed [5:0] ACT_VOL_OCT_BIAS = 6'sh0E;
    localparam int ACT_PHASE_MAX = 63;
    // fixed point scaling of the gain tables
    localparam int ACT_FINE_FRAC = 15;
    localparam int ACT_MANT_FRAC = 14;
    localparam int ACT_WIDE = 48;
endpackage

//--- logic/act_channel_trim.sv
// Notes on behaviour
// (R1) volume code zero fully mutes the channel output samples
// (R2) volume code 1 gives -80 dB, code 2 gives -79.5 dB
// (R3) volume code 161 is unity gain, code 162 is +0.5 dB
// (R4) volume code 254 gives +46.5 dB, code 255 gives +47 dB
// (R5) volume registers reset to 0xA1; channel 2 volume at 0x57
// (R6) fine gain sits in bits 7..4; code zero gives -0.8 dB
// (R7) fine gain code 8 is 0 dB, code 9 is +0.1 dB
// (R8) fine gain code 14 is +0.6 dB, code 15 is +0.7 dB
// (R9) fine gain registers reset to 0x80; channel 2 fine gain at 0x58
// (R10) channel 2 phase code in bits 7..2; zero means no delay
// (R11) nonzero phase code delays channel 2 by that many modulator cycles, max 63
// (R12) channel 2 phase register at 0x59 resets to 0x00
// (R13) bit 7 at 0x5A set feeds channel 3 with channel 1's input
// (R14) channel 3 copy register at 0x5A resets to 0x00
// (R15) software writes only reset values to reserved bits, which read back fixed
// (R16) between code points gain steps 0.5 dB per volume, 0.1 dB per fine code
`timescale 1ns/10ps
`default_nettype none
module act_channel_trim
    import act_pkg::*;
#(
    parameter int W = 24,
    parameter int DLY_DEPTH = 63
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic mod_tick,
    input wire logic signed [W-1:0] ch1_sample,
    input wire logic signed [W-1:0] ch2_sample,
    input wire logic signed [W-1:0] ch3_sample,
    output logic signed [W-1:0] ch2_out,
    output logic signed [W-1:0] ch3_out,
    output logic out_valid
);

    ////////////////////////////////////////////////////////////////////////////
    // gain tables

    // half-decibel steps within one octave, Q2.14
    function automatic logic [15:0] vol_mant(input logic [3:0] r);
        case (r)
            4'h0: vol_mant = 16'h4000;
            4'h1: vol_mant = 16'h43CB;
            4'h2: vol_mant = 16'h47CF;
            4'h3: vol_mant = 16'h4C10;
            4'h4: vol_mant = 16'h5092;
            4'h5: vol_mant = 16'h5558;
            4'h6: vol_mant = 16'h5A67;
            4'h7: vol_mant = 16'h5FC2;
            4'h8: vol_mant = 16'h656F;
            4'h9: vol_mant = 16'h6B72;
            4'hA: vol_mant = 16'h71CF;
            4'hB: vol_mant = 16'h788E;
            default: vol_mant = 16'h4000;
        endcase
    endfunction

    // tenth-decibel fine trim, -0.8 dB .. +0.7 dB, Q1.15
    function automatic logic [15:0] fine_mult(input logic [3:0] f);
        case (f)
            4'h0: fine_mult = 16'h74BD;
            4'h1: fine_mult = 16'h7617;
            4'h2: fine_mult = 16'h7775;
            4'h3: fine_mult = 16'h78D7;
            4'h4: fine_mult = 16'h7A3D;
            4'h5: fine_mult = 16'h7BA8;
            4'h6: fine_mult = 16'h7D16;
            4'h7: fine_mult = 16'h7E89;
            4'h8: fine_mult = 16'h8000;
            4'h9: fine_mult = 16'h817C;
            4'hA: fine_mult = 16'h82FB;
            4'hB: fine_mult = 16'h8480;
            4'hC: fine_mult = 16'h8608;
            4'hD: fine_mult = 16'h8796;
            4'hE: fine_mult = 16'h8928;
            default: fine_mult = 16'h8ABF;
        endcase
    endfunction

    // code 161 lands on octave 0, step 0; each 12 codes is one octave
    function automatic logic signed [5:0] vol_octave(input logic [7:0] v);
        logic [8:0] n;
        n = {1'b0, v} + ACT_VOL_BIAS;
        vol_octave = $signed({1'b0, 5'(n / ACT_VOL_STEPS_PER_OCT)}) - ACT_VOL_OCT_BIAS;
    endfunction

    function automatic logic [3:0] vol_step(input logic [7:0] v);
        logic [8:0] n;
        n = {1'b0, v} + ACT_VOL_BIAS;
        vol_step = 4'(n % ACT_VOL_STEPS_PER_OCT);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // control registers

    logic [7:0] ch2_vol_reg;
    logic [7:0] ch2_fine_reg;
    logic [7:0] ch2_phase_reg;
    logic [7:0] ch3_copy_reg;
    logic [7:0] ch3_vol_reg;
    logic [7:0] ch3_fine_reg;
    logic [7:0] reg_rdata_next;

    wire wr_en = ce && reg_wr;
    wire sel_ch2_vol = reg_addr == ACT_OFS_CH2_VOL;
    wire sel_ch2_fine = reg_addr == ACT_OFS_CH2_FINE;
    wire sel_ch2_phase = reg_addr == ACT_OFS_CH2_PHASE;
    wire sel_ch3_copy = reg_addr == ACT_OFS_CH3_COPY;
    wire sel_ch3_vol = reg_addr == ACT_OFS_CH3_VOL;
    wire sel_ch3_fine = reg_addr == ACT_OFS_CH3_FINE;

    // per-register write strobes
    wire wr_ch2_vol = wr_en && sel_ch2_vol;
    wire wr_ch2_fine = wr_en && sel_ch2_fine;
    wire wr_ch2_phase = wr_en && sel_ch2_phase;
    wire wr_ch3_copy = wr_en && sel_ch3_copy;
    wire wr_ch3_vol = wr_en && sel_ch3_vol;
    wire wr_ch3_fine = wr_en && sel_ch3_fine;

    // reserved bits stay at their reset value whatever is written
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ch2_vol_reg <= ACT_RST_VOL; // R5
        end else if (wr_ch2_vol) begin
            ch2_vol_reg <= reg_wdata & ACT_MASK_VOL;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ch2_fine_reg <= ACT_RST_FINE; // R9
        end else if (wr_ch2_fine) begin
            ch2_fine_reg <= reg_wdata & ACT_MASK_FINE; // R15
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ch2_phase_reg <= ACT_RST_PHASE; // R12
        end else if (wr_ch2_phase) begin
            ch2_phase_reg <= reg_wdata & ACT_MASK_PHASE; // R15
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ch3_copy_reg <= ACT_RST_COPY; // R14
        end else if (wr_ch3_copy) begin
            ch3_copy_reg <= reg_wdata & ACT_MASK_COPY; // R15
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ch3_vol_reg <= ACT_RST_VOL; // R5
        end else if (wr_ch3_vol) begin
            ch3_vol_reg <= reg_wdata & ACT_MASK_VOL;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ch3_fine_reg <= ACT_RST_FINE; // R9
        end else if (wr_ch3_fine) begin
            ch3_fine_reg <= reg_wdata & ACT_MASK_FINE; // R15
        end
    end

    assign reg_rdata_next = sel_ch2_vol ? ch2_vol_reg :
                            sel_ch2_fine ? ch2_fine_reg :
                            sel_ch2_phase ? ch2_phase_reg :
                            sel_ch3_copy ? ch3_copy_reg :
                            sel_ch3_vol ? ch3_vol_reg :
                            sel_ch3_fine ? ch3_fine_reg : 8'h00;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (ce && reg_rd) begin
            reg_rdata <= reg_rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // channel 2 phase delay line, one word per modulator cycle

    logic signed [W-1:0] dly_line [DLY_DEPTH];
    wire [5:0] ch2_phase_delay_code = ch2_phase_reg[ACT_PHASE_LSB +: 6]; // R10

    // reset clears the line so early taps read as silence
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < DLY_DEPTH; i++) begin
                dly_line[i] <= '0;
            end
        end else if (ce && mod_tick) begin
            dly_line[0] <= ch2_sample;
            for (int i = 1; i < DLY_DEPTH; i++) begin
                dly_line[i] <= dly_line[i-1];
            end
        end
    end

    // tap k-1 holds the word taken k ticks ago
    // a code change jumps taps at once; no crossfade is applied
    wire signed [W-1:0] ch2_src = (ch2_phase_delay_code == 6'h00) ? ch2_sample : // R10
                                  dly_line[ch2_phase_delay_code - 6'h01]; // R11

    wire ch3_copy_ch1_input = ch3_copy_reg[ACT_COPY_BIT];
    wire signed [W-1:0] ch3_src = ch3_copy_ch1_input ? ch1_sample : ch3_sample; // R13

    ////////////////////////////////////////////////////////////////////////////
    // gain pipeline: fine trim, volume step, octave shift with saturation

    logic [2:0] vld_reg;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            vld_reg <= 3'h0;
        end else if (ce) begin
            vld_reg <= {vld_reg[1:0], mod_tick};
        end
    end

    assign out_valid = vld_reg[2];

    wire signed [W-1:0] src_w [2];
    wire [7:0] vol_w [2];
    wire [7:0] fine_w [2];
    assign src_w[0] = ch2_src;
    assign src_w[1] = ch3_src;
    assign vol_w[0] = ch2_vol_reg;
    assign vol_w[1] = ch3_vol_reg;
    assign fine_w[0] = ch2_fine_reg;
    assign fine_w[1] = ch3_fine_reg;

    localparam logic signed [ACT_WIDE-1:0] SAT_MAX = ACT_WIDE'((64'sd1 <<< (W - 1)) - 64'sd1);
    localparam logic signed [ACT_WIDE-1:0] SAT_MIN = ACT_WIDE'(-(64'sd1 <<< (W - 1)));

    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic signed [W:0] a_reg;
        logic signed [W+1:0] b_reg;
        logic signed [5:0] oct_reg;
        logic mute_reg;
        logic signed [W-1:0] out_reg;

        wire [3:0] fine_gain_code = fine_w[c][ACT_FINE_LSB +: 4]; // R6
        wire signed [16:0] fine_s = $signed({1'b0, fine_mult(fine_gain_code)}); // R6 R7 R8 R16
        wire signed [W+16:0] a_prod = src_w[c] * fine_s;
        wire signed [16:0] mant_s = $signed({1'b0, vol_mant(vol_step(vol_w[c]))}); // R2 R3 R4 R16
        wire signed [W+17:0] b_prod = a_reg * mant_s;
        wire signed [ACT_WIDE-1:0] b_wide = ACT_WIDE'(b_reg);
        wire [5:0] oct_neg = 6'(-oct_reg);
        wire signed [ACT_WIDE-1:0] shifted = oct_reg[5] ? (b_wide >>> oct_neg) :
                                             (b_wide <<< oct_reg[4:0]);
        wire signed [W-1:0] sat = (shifted > SAT_MAX) ? SAT_MAX[W-1:0] :
                                  (shifted < SAT_MIN) ? SAT_MIN[W-1:0] : shifted[W-1:0];

        // stage a: fine trim
        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                a_reg <= '0;
            end else if (ce) begin
                a_reg <= a_prod[W+ACT_FINE_FRAC:ACT_FINE_FRAC];
            end
        end

        // stage b: volume mantissa, octave and mute
        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                b_reg <= '0;
                oct_reg <= '0;
                mute_reg <= 1'b0;
            end else if (ce) begin
                b_reg <= b_prod[W+1+ACT_MANT_FRAC:ACT_MANT_FRAC];
                oct_reg <= vol_octave(vol_w[c]); // R2 R3 R4
                mute_reg <= vol_w[c] == ACT_VOL_MUTE; // R1
            end
        end

        // stage c: shift and saturate, or zero on mute
        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                out_reg <= '0;
            end else if (ce) begin
                out_reg <= mute_reg ? '0 : sat; // R1
            end
        end
    end

    assign ch2_out = g_ch[0].out_reg;
    assign ch3_out = g_ch[1].out_reg;

endmodule
`default_nettype wire

//--- testbench/act_trim_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module act_trim_monitor
    import act_pkg::*;
#(
    parameter int W = 24
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic mod_tick,
    input wire logic signed [W-1:0] ch2_out,
    input wire logic out_valid
);
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////
    property p_lat; ce && mod_tick ##1 ce [*2] |=> out_valid; endproperty
    a_lat: assert property (p_lat) else $error("out_valid late");
    property p_frz; !ce |=> $stable(reg_rdata) && $stable(out_valid) && $stable(ch2_out); endproperty
    a_frz: assert property (p_frz) else $error("moved while ce low");
    property p_hold; !(ce && reg_rd) |=> $stable(reg_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data changed");
    property p_unmap; ce && reg_rd && (reg_addr < 8'h57 || reg_addr > 8'h5C) |=> reg_rdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_rsv58; ce && reg_rd && reg_addr == ACT_OFS_CH2_FINE |=> reg_rdata[3:0] == 4'h0; endproperty
    a_rsv58: assert property (p_rsv58) else $error("fine trim low bits set");
    property p_rsv5a; ce && reg_rd && reg_addr == ACT_OFS_CH3_COPY |=> reg_rdata[6:0] == 7'h00; endproperty
    a_rsv5a: assert property (p_rsv5a) else $error("copy select low bits set");
    property p_rdbk;
        ce && reg_wr && reg_addr == ACT_OFS_CH2_VOL ##1 ce && !reg_wr
            ##1 ce && reg_rd && !reg_wr && reg_addr == ACT_OFS_CH2_VOL |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    a_rdbk: assert property (p_rdbk) else $error("volume readback wrong");
    property p_rst; $rose(rstn) |-> reg_rdata == 8'h00 && !out_valid; endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule
bind act_channel_trim act_trim_monitor #(.W(W)) u_mon (.ref_clk, .rstn, .ce, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .mod_tick, .ch2_out, .out_valid);
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import act_pkg::*;
    logic ref_clk = 0, rstn = 0, ce = 1, reg_wr = 0, reg_rd = 0, mod_tick = 0, ov;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
    logic signed [23:0] s1 = 0, s2 = 0, s3 = 0, o2, o3;
    int miscompares = 0, n_checks = 0, cyc = 0;
    int ph [2] = '{1, 63};
    logic [7:0] rv [6] = '{ACT_RST_VOL, ACT_RST_FINE, ACT_RST_PHASE, ACT_RST_COPY, ACT_RST_VOL, ACT_RST_FINE};
    logic [7:0] mk [6] = '{ACT_MASK_VOL, ACT_MASK_FINE, ACT_MASK_PHASE, ACT_MASK_COPY, ACT_MASK_VOL, ACT_MASK_FINE};
    act_channel_trim u_dut (.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mod_tick(mod_tick), .ch1_sample(s1),
        .ch2_sample(s2), .ch3_sample(s3), .ch2_out(o2), .ch3_out(o3), .out_valid(ov));
    always #10 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////
    task finish_test;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            finish_test;
        end
    end
    task chk(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk(24'(reg_rdata), 24'(e));
    endtask
    task send(input logic signed [23:0] a, b, c, e2, e3, input bit c2);
        @(posedge ref_clk);
        s1 <= a;
        s2 <= b;
        s3 <= c;
        mod_tick <= 1'b1;
        @(posedge ref_clk);
        mod_tick <= 1'b0;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        chk(24'(ov), 24'h1);
        if (c2)
            chk(o2, e2);
        chk(o3, e3);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        for (int r = 0; r < 2; r++) begin
            @(posedge ref_clk);
            rstn <= 1'b0;
            repeat (8) @(posedge ref_clk);
            rstn <= 1'b1;
            for (int i = 0; i < 6; i++)
                rd(8'h57 + 8'(i), rv[i]);
            rd(8'h56, 8'h00);
            rd(8'h5D, 8'h00);
            $display("test reset done");
            if (r == 0) begin
                for (int i = 0; i < 6; i++) begin
                    wr(8'h57 + 8'(i), 8'hFF);
                    rd(8'h57 + 8'(i), mk[i]);
                    wr(8'h57 + 8'(i), rv[i]);
                end
                @(posedge ref_clk);
                ce <= 1'b0;
                reg_addr <= 8'h57;
                reg_rd <= 1'b1;
                repeat (2) @(posedge ref_clk);
                reg_rd <= 1'b0;
                ce <= 1'b1;
                @(negedge ref_clk);
                chk(24'(reg_rdata), 24'(mk[5]));
                $display("test registers done");
                send(24'h000100, 24'h012345, 24'h654321, 24'h012345, 24'h654321, 1);
                wr(ACT_OFS_CH2_VOL, 8'h00);
                wr(ACT_OFS_CH3_VOL, 8'd173);
                send(24'h000100, 24'h012345, 24'h001000, 24'h0, 24'h002000, 1);
                wr(ACT_OFS_CH3_VOL, 8'd149);
                send(24'h000100, 24'h012345, 24'h001000, 24'h0, 24'h000800, 1);
                wr(ACT_OFS_CH2_VOL, ACT_RST_VOL);
                wr(ACT_OFS_CH3_VOL, ACT_RST_VOL);
                wr(ACT_OFS_CH3_COPY, 8'h80);
                send(24'h0ABCDE, 24'h000111, 24'h000222, 24'h000111, 24'h0ABCDE, 1);
                wr(ACT_OFS_CH3_COPY, 8'h00);
                $display("test gain done");
                for (int j = 0; j < 2; j++) begin
                    wr(ACT_OFS_CH2_PHASE, 8'(ph[j] << 2));
                    for (int k = 0; k <= ph[j] + 1; k++)
                        send(0, 24'(256 + k), 24'h5, 24'(256 + k - ph[j]), 24'h5, k >= ph[j]);
                end
                $display("test delay done");
            end
        end
        finish_test;
    end
endmodule
`default_nettype wire
